// ---- hw/gds_consts.svh ----
`ifndef GDS_CONSTS_SVH
`define GDS_CONSTS_SVH

// System clock and input filtering
`define GDS_CLK_PERIOD_NS 100
`define GDS_FILT_NS 20
// A pulse shorter than the filter time hits at most one sample; demand one more
`define GDS_FILT_CYC (((`GDS_FILT_NS + `GDS_CLK_PERIOD_NS - 1) / `GDS_CLK_PERIOD_NS) + 1)

// Frame layout
`define GDS_FRAME_BITS 40
`define GDS_ADDR_BITS 8
`define GDS_WRITE_BIT 39

// Register addresses (7-bit, write adds 8'h80)
`define GDS_ADDR_GSTAT 7'h00
`define GDS_ADDR_GCFG 7'h01

// Reset values and implemented-bit masks
`define GDS_GCFG_RST 32'h0000_0002
`define GDS_GCFG_MASK 32'h0000_00F7
`define GDS_GSTAT_RST 32'h0000_0001
`define GDS_GSTAT_MASK 32'h0000_0003
`define GDS_GSTAT_RESET_BIT 0
`define GDS_GSTAT_OC_BIT 1

// Filtered input lanes
`define GDS_IN_SCK 0
`define GDS_IN_SDI 1
`define GDS_IN_CSN 2
`define GDS_IN_BEN 3
`define GDS_IN_HS 4
`define GDS_IN_LS 7
`define GDS_IN_W 10
`define GDS_IN_RST 10'h00D

`endif

// ---- hw/gds_in_filter.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "gds_consts.svh"

module gds_in_filter #(
  parameter int          W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_srst,
  input  wire logic [W-1:0] i_raw,
  output logic      [W-1:0] o_filt
);
  localparam logic [1:0] LAST = 2'(`GDS_FILT_CYC - 1);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] out_r;
  logic [W-1:0] out_nxt;

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      s1_r  <= RST_VAL;
      s2_r  <= RST_VAL;
      out_r <= RST_VAL;
    end else begin
      s1_r  <= i_raw;
      s2_r  <= s1_r;
      out_r <= out_nxt;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_lane
      logic [1:0] cnt_r;
      logic [1:0] cnt_nxt;
      logic       bit_nxt;

      // Output moves only after the new level held for the whole filter time
      always_comb begin
        cnt_nxt = 2'h0;
        bit_nxt = out_r[gi];
        if (s2_r[gi] != out_r[gi]) begin
          if (cnt_r == LAST) begin
            bit_nxt = s2_r[gi];
          end else begin
            cnt_nxt = cnt_r + 2'h1;
          end
        end
      end

      always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
          cnt_r <= 2'h0;
        end else begin
          cnt_r <= cnt_nxt;
        end
      end

      assign out_nxt[gi] = bit_nxt;
    end
  endgenerate

  assign o_filt = out_r;

endmodule // gds_in_filter
`default_nettype wire

// ---- hw/gds_pkg.sv ----
`default_nettype none
package gds_pkg;

  typedef struct packed {
    logic sck;
    logic sdi;
    logic csn_n;
  } gds_spi_pins_t;

  typedef struct packed {
    logic [23:0] unused_hi;
    logic        test_mode;
    logic        amplifier_off;
    logic [1:0]  amplification;
    logic        unused_3;
    logic        fault_direct;
    logic        single_line;
    logic        driver_disable;
  } gds_glob_cfg_t;

  typedef struct packed {
    logic [2:0] hs;
    logic [2:0] ls;
  } gds_gates_t;

  typedef enum logic {
    GDS_ST_IDLE,
    GDS_ST_FRAME
  } gds_state_t;

endpackage
`default_nettype wire

// ---- hw/gds_spi_port.sv ----
// Functional notes
// - Serial inputs and bridge enable ignore pulses shorter than about 20 ns.
// - Mode 3: clock idles high, sample on rise, change output after fall.
// - Power-up clears registers to zero except documented nonzero defaults.
// - Fields are read only, write only, read-write or write-one-to-clear.
// - Configuration bit 0 set disables the bridge driver.
// - Bit 1 resets to one: high input is phase control, low is enable.
// - Bit 1 zero: separate high and low gate commands per phase.
// - Frame is 40 bits MSB first: address byte then 32 data bits.
// - Address byte MSB zero reads, one writes.
// - Received frame is committed only when chip select returns high.
// - Bit 2 zero: fault shows continuous shutdown; one: pulses per overcurrent.
`timescale 1ns/1ps
`default_nettype none
`include "gds_consts.svh"

module gds_spi_port (
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_srst,
  input  wire gds_pkg::gds_spi_pins_t i_spi,
  input  wire logic                  i_bridge_enable_input_low,
  input  wire gds_pkg::gds_gates_t   i_gate_in,
  input  wire logic                  i_bridge_shutdown,
  input  wire logic                  i_oc_action,
  output logic                       o_sdo,
  output logic                       o_sdo_oe,
  output gds_pkg::gds_gates_t        o_gate,
  output logic                       o_fault,
  output gds_pkg::gds_glob_cfg_t     o_global_configuration
);
  import gds_pkg::*;

  localparam logic [5:0] FRAME_LAST = 6'(`GDS_FRAME_BITS - 1);
  localparam logic [5:0] ADDR_LAST  = 6'(`GDS_ADDR_BITS - 1);
  localparam logic [5:0] FRAME_LEN  = 6'(`GDS_FRAME_BITS);

  function automatic logic [31:0] read_reg(input logic [6:0] addr,
                                           input logic [31:0] gcfg,
                                           input logic [31:0] gstat);
    if (addr == `GDS_ADDR_GCFG) begin
      read_reg = gcfg & `GDS_GCFG_MASK;
    end else if (addr == `GDS_ADDR_GSTAT) begin
      read_reg = gstat & `GDS_GSTAT_MASK;
    end else begin
      read_reg = 32'h0000_0000;
    end
  endfunction

  // Input conditioning
  logic [`GDS_IN_W-1:0] raw;
  logic [`GDS_IN_W-1:0] filt;

  assign raw = {i_gate_in.ls, i_gate_in.hs, i_bridge_enable_input_low,
                i_spi.csn_n, i_spi.sdi, i_spi.sck};

  gds_in_filter #(
    .W       (`GDS_IN_W),
    .RST_VAL (`GDS_IN_RST)
  ) u_filt (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_raw     (raw),
    .o_filt    (filt)
  );

  logic       f_sck;
  logic       f_sdi;
  logic       f_csn;
  logic       f_ben_n;
  logic [2:0] f_hs;
  logic [2:0] f_ls;

  assign f_sck = filt[`GDS_IN_SCK];
  assign f_sdi = filt[`GDS_IN_SDI];
  assign f_csn = filt[`GDS_IN_CSN];
  assign f_ben_n = filt[`GDS_IN_BEN];
  assign f_hs  = filt[`GDS_IN_HS +: 3];
  assign f_ls  = filt[`GDS_IN_LS +: 3];

  // Serial engine state
  gds_state_t  state_r;
  gds_state_t  state_nxt;
  logic        sck_d_r;
  logic        csn_d_r;
  logic [39:0] shift_r;
  logic [39:0] shift_nxt;
  logic [5:0]  cnt_r;
  logic [5:0]  cnt_nxt;
  logic [5:0]  out_sel_r;
  logic [5:0]  out_sel_nxt;
  logic [31:0] rd_r;
  logic [31:0] rd_nxt;
  logic [7:0]  last_addr_r;
  logic [7:0]  last_addr_nxt;
  logic        sdo_r;
  logic        sdo_nxt;
  logic [39:0] out_word;
  logic        commit;
  logic        sck_rise;
  logic        sck_fall;
  logic        cs_start;
  logic        cs_end;

  // Register file state
  gds_glob_cfg_t gcfg_r;
  gds_glob_cfg_t gcfg_nxt;
  logic [31:0]   gstat_r;
  logic [31:0]   gstat_nxt;

  assign sck_rise = f_sck & ~sck_d_r;
  assign sck_fall = ~f_sck & sck_d_r;
  assign cs_start = csn_d_r & ~f_csn;
  assign cs_end   = ~csn_d_r & f_csn;

  always_comb begin
    state_nxt     = state_r;
    shift_nxt     = shift_r;
    cnt_nxt       = cnt_r;
    out_sel_nxt   = out_sel_r;
    rd_nxt        = rd_r;
    last_addr_nxt = last_addr_r;
    commit        = 1'b0;
    case (state_r)
      GDS_ST_IDLE: begin
        if (cs_start) begin
          state_nxt   = GDS_ST_FRAME;
          cnt_nxt     = 6'h00;
          out_sel_nxt = 6'h00;
          rd_nxt      = 32'h0000_0000;
        end
      end
      GDS_ST_FRAME: begin
        if (cs_end) begin
          // Short frames are dropped; longer ones keep the last 40 bits
          commit    = (cnt_r >= FRAME_LEN);
          state_nxt = GDS_ST_IDLE;
          if (commit) begin
            last_addr_nxt = shift_r[39:32];
          end
        end else if (sck_rise) begin
          shift_nxt = {shift_r[38:0], f_sdi};
          if (cnt_r != FRAME_LEN) begin
            cnt_nxt = cnt_r + 6'h01;
          end
          // Internal read happens as soon as the address byte is in
          if (cnt_r == ADDR_LAST) begin
            rd_nxt = read_reg(shift_nxt[6:0], gcfg_r, gstat_r);
          end
        end else if (sck_fall && cnt_r != 6'h00 && cnt_r <= FRAME_LAST) begin
          out_sel_nxt = cnt_r;
        end
      end
      default: begin
        state_nxt = GDS_ST_IDLE;
      end
    endcase
    // Status byte echoes the last committed frame's address byte (zero after reset), then read data
    out_word = {last_addr_r, rd_nxt};
    sdo_nxt  = 1'b0;
    if (state_nxt == GDS_ST_FRAME) begin
      sdo_nxt = out_word[FRAME_LAST - out_sel_nxt];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      state_r     <= GDS_ST_IDLE;
      sck_d_r     <= 1'b1;
      csn_d_r     <= 1'b1;
      shift_r     <= 40'h00_0000_0000;
      cnt_r       <= 6'h00;
      out_sel_r   <= 6'h00;
      rd_r        <= 32'h0000_0000;
      last_addr_r <= 8'h00;
      sdo_r       <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      sck_d_r     <= f_sck;
      csn_d_r     <= f_csn;
      shift_r     <= shift_nxt;
      cnt_r       <= cnt_nxt;
      out_sel_r   <= out_sel_nxt;
      rd_r        <= rd_nxt;
      last_addr_r <= last_addr_nxt;
      sdo_r       <= sdo_nxt;
    end
  end

  // Register writes
  logic        wr_en;
  logic [6:0]  wr_addr;
  logic [31:0] wr_data;
  logic [31:0] gstat_set;
  logic [31:0] gstat_clr;

  assign wr_en   = commit & shift_r[`GDS_WRITE_BIT];
  assign wr_addr = shift_r[38:32];
  assign wr_data = shift_r[31:0];

  always_comb begin
    gcfg_nxt  = gcfg_r;
    gstat_set = 32'h0000_0000;
    gstat_clr = 32'h0000_0000;
    if (wr_en && wr_addr == `GDS_ADDR_GCFG) begin
      gcfg_nxt = gds_glob_cfg_t'(wr_data & `GDS_GCFG_MASK);
    end
    if (wr_en && wr_addr == `GDS_ADDR_GSTAT) begin
      gstat_clr = wr_data & `GDS_GSTAT_MASK;
    end
    gstat_set[`GDS_GSTAT_OC_BIT] = i_oc_action;
    // A new event in the clearing cycle survives the clear
    gstat_nxt = (gstat_r & ~gstat_clr) | gstat_set;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      gcfg_r  <= gds_glob_cfg_t'(`GDS_GCFG_RST);
      gstat_r <= `GDS_GSTAT_RST;
    end else begin
      gcfg_r  <= gcfg_nxt;
      gstat_r <= gstat_nxt;
    end
  end

  // Bridge control path
  gds_gates_t gate_r;
  gds_gates_t gate_nxt;
  logic       fault_r;
  logic       fault_nxt;
  logic       drive_ok;

  always_comb begin
    drive_ok = ~gcfg_r.driver_disable & ~f_ben_n;
    if (gcfg_r.single_line) begin
      // Low input gates the phase, high input picks which switch conducts
      gate_nxt.hs = {3{drive_ok}} & f_ls & f_hs;
      gate_nxt.ls = {3{drive_ok}} & f_ls & ~f_hs;
    end else begin
      gate_nxt.hs = {3{drive_ok}} & f_hs;
      gate_nxt.ls = {3{drive_ok}} & f_ls;
    end
    fault_nxt = gcfg_r.fault_direct ? i_oc_action : i_bridge_shutdown;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      gate_r  <= '0;
      fault_r <= 1'b0;
    end else begin
      gate_r  <= gate_nxt;
      fault_r <= fault_nxt;
    end
  end

  assign o_sdo                  = sdo_r;
  assign o_sdo_oe               = (state_r == GDS_ST_FRAME);
  assign o_gate                 = gate_r;
  assign o_fault                = fault_r;
  assign o_global_configuration = gcfg_r;

endmodule // gds_spi_port
`default_nettype wire

// ---- tb/gds_spi_master.sv ----
`timescale 1ns/1ps
`default_nettype none
module gds_spi_master (
  input  wire logic                  i_sdo,
  output var gds_pkg::gds_spi_pins_t o_spi
);
  import gds_pkg::*;
  initial o_spi = 3'b111;
  // 800 ns link period: well under a quarter and a sixth of the system clock
  task automatic xfer(input logic [39:0] tx, input int n, output logic [39:0] rx);
    rx = '0;
    #37;
    o_spi.csn_n = 1'b0;
    #800;
    for (int i = 0; i < n; i++) begin
      o_spi.sck = 1'b0;
      o_spi.sdi = tx[39-i];
      #400;
      o_spi.sck = 1'b1;
      #390;
      // Late sample: the port answers several system cycles after the fall
      rx = {rx[38:0], i_sdo};
      #10;
    end
    o_spi.csn_n = 1'b1;
    o_spi.sdi = ~o_spi.sdi;
    #1000;
  endtask
endmodule // gds_spi_master
`default_nettype wire

// ---- tb/gds_spi_port_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module gds_spi_port_sva (
  input wire logic                   i_clk_sys,
  input wire logic                   i_srst,
  input wire gds_pkg::gds_spi_pins_t i_spi,
  input wire logic                   i_bridge_shutdown,
  input wire logic                   i_oc_action,
  input wire logic                   o_sdo,
  input wire logic                   o_sdo_oe,
  input wire gds_pkg::gds_gates_t    o_gate,
  input wire logic                   o_fault,
  input wire gds_pkg::gds_glob_cfg_t o_global_configuration
);
  import gds_pkg::*;
  gds_glob_cfg_t c;
  assign c = o_global_configuration;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  reset_values_a: assert property (disable iff (1'b0)
    $fell(i_srst) |-> c == 32'h0000_0002 && !o_sdo_oe && o_gate == '0 && !o_fault)
    else $error("reset values wrong");
  commit_hold_a: assert property (o_sdo_oe |-> $stable(c))
    else $error("config changed inside a frame");
  unused_zero_a: assert property (c[31:8] == '0 && !c[3])
    else $error("unused config bits set");
  sdo_idle_a: assert property (!o_sdo_oe [*2] |-> !o_sdo)
    else $error("sdo not low outside frame");
  select_low_a: assert property (!i_spi.csn_n [*8] |-> o_sdo_oe)
    else $error("frame not seen");
  select_high_a: assert property (i_spi.csn_n [*8] |-> !o_sdo_oe)
    else $error("frame not closed");
  drv_off_a: assert property (c.driver_disable [*3] |-> o_gate == '0)
    else $error("gates on while disabled");
  single_safe_a: assert property (c.single_line [*3] |-> (o_gate.hs & o_gate.ls) == '0)
    else $error("both switches on");
  fault_pulse_a: assert property (c.fault_direct ##1 c.fault_direct |->
    o_fault == $past(i_oc_action)) else $error("fault pulse wrong");
  fault_level_a: assert property (!c.fault_direct ##1 !c.fault_direct |->
    o_fault == $past(i_bridge_shutdown)) else $error("fault level wrong");
  cover property ($rose(o_sdo_oe));
  cover property ($changed(c));
  cover property (c.fault_direct && o_fault);
endmodule // gds_spi_port_sva
bind gds_spi_port gds_spi_port_sva u_sva (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
  .i_spi(i_spi), .i_bridge_shutdown(i_bridge_shutdown), .i_oc_action(i_oc_action),
  .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe), .o_gate(o_gate), .o_fault(o_fault),
  .o_global_configuration(o_global_configuration));
`default_nettype wire

// ---- tb/gds_spi_port_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module gds_spi_port_test;
  import gds_pkg::*;
  logic          i_clk_sys;
  logic          i_srst;
  logic          ben_n;
  logic          shut;
  logic          oc;
  logic          sdo;
  logic          sdo_oe;
  logic          fault;
  gds_spi_pins_t spi;
  gds_gates_t    gin;
  gds_gates_t    gout;
  gds_glob_cfg_t cfg;
  logic [39:0]   rx;
  logic [31:0]   d;
  int            errors;
  int            compares;
  gds_spi_port u_dut (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_spi(spi),
    .i_bridge_enable_input_low(ben_n), .i_gate_in(gin), .i_bridge_shutdown(shut),
    .i_oc_action(oc), .o_sdo(sdo), .o_sdo_oe(sdo_oe), .o_gate(gout),
    .o_fault(fault), .o_global_configuration(cfg));
  gds_spi_master u_mst (.i_sdo(sdo), .o_spi(spi));
  initial begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end
  task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask
  task automatic wr(input logic [6:0] a, input logic [31:0] v);
    u_mst.xfer({1'b1, a, v}, 40, rx);
    cyc(4);
  endtask
  task automatic rd(input logic [6:0] a);
    u_mst.xfer({1'b0, a, 32'h0000_0000}, 40, rx);
    d = rx[31:0];
    cyc(4);
  endtask
  task automatic t_reset();
    chk("cfg port", 32'h0000_0002, cfg);
    chk("oe idle", 1'b0, sdo_oe);
    fork
      rd(7'h01);
      begin
        cyc(20);
        #1 chk("oe in frame", 1'b1, sdo_oe);
      end
    join
    chk("cfg read", 32'h0000_0002, d);
    chk("oe after", 1'b0, sdo_oe);
    rd(7'h00);
    chk("status", 32'h0000_0001, d);
    chk("prev addr", 8'h01, rx[39:32]);
  endtask
  task automatic t_write();
    wr(7'h01, 32'hFFFF_FFFF);
    chk("cfg all ones", 32'h0000_00F7, cfg);
    rd(7'h01);
    chk("cfg back", 32'h0000_00F7, d);
    chk("prev wr addr", 8'h81, rx[39:32]);
    u_mst.xfer({8'h81, 32'h0000_0000}, 39, rx);
    cyc(4);
    chk("short frame", 32'h0000_00F7, cfg);
    wr(7'h01, 32'h0000_0000);
  endtask
  task automatic t_status();
    wr(7'h00, 32'h0000_0001);
    rd(7'h00);
    chk("flag cleared", 32'h0000_0000, d);
    wr(7'h05, 32'hFFFF_FFFF);
    rd(7'h05);
    chk("unmapped read", 32'h0000_0000, d);
    chk("unmapped write", 32'h0000_0000, cfg);
    oc <= 1'b1;
    cyc(1);
    oc <= 1'b0;
    rd(7'h00);
    chk("oc flag", 32'h0000_0002, d);
    wr(7'h00, 32'h0000_0002);
    rd(7'h00);
    chk("oc cleared", 32'h0000_0000, d);
  endtask
  task automatic t_gates();
    gin <= {3'b101, 3'b011};
    ben_n <= 1'b0;
    cyc(10);
    chk("six line", 6'b101011, gout);
    wr(7'h01, 32'h0000_0002);
    chk("single line", 6'b001010, gout);
    ben_n <= 1'b1;
    cyc(1);
    ben_n <= 1'b0;
    // A one-cycle pulse must not reach the gates
    for (int i = 0; i < 8; i++) begin
      cyc(1);
      #1 chk("bridge glitch", 6'b001010, gout);
    end
    wr(7'h01, 32'h0000_0003);
    chk("disabled", 6'b000000, gout);
    wr(7'h01, 32'h0000_0002);
    ben_n <= 1'b1;
    cyc(10);
    chk("bridge off", 6'b000000, gout);
  endtask
  task automatic t_fault();
    wr(7'h01, 32'h0000_0000);
    shut <= 1'b1;
    cyc(3);
    chk("fault level", 1'b1, fault);
    shut <= 1'b0;
    wr(7'h01, 32'h0000_0004);
    oc <= 1'b1;
    cyc(1);
    oc <= 1'b0;
    #1 chk("fault pulse", 1'b1, fault);
    cyc(1);
    #1 chk("pulse end", 1'b0, fault);
  endtask
  task automatic t_rerst();
    wr(7'h01, 32'h0000_0015);
    i_srst <= 1'b1;
    cyc(3);
    i_srst <= 1'b0;
    cyc(6);
    chk("cfg reset again", 32'h0000_0002, cfg);
    rd(7'h00);
    chk("reset flag again", 32'h0000_0001, d);
    chk("prev addr reset", 8'h00, rx[39:32]);
  endtask
  task automatic wrap_up();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #2_000_000;
    errors++;
    wrap_up();
  end
  initial begin
    i_srst = 1'b1;
    ben_n = 1'b1;
    gin = '0;
    shut = 1'b0;
    oc = 1'b0;
    errors = 0;
    compares = 0;
    cyc(6);
    i_srst <= 1'b0;
    cyc(6);
    t_reset();
    t_write();
    t_status();
    t_gates();
    t_fault();
    t_rerst();
    wrap_up();
  end
endmodule // gds_spi_port_test
`default_nettype wire
